// ### rtl/isrb_slave.sv
// Two-wire slave with 32-byte dual-port buffer, APB registers, compatible and buffered modes.
// Assumes open-drain pads outside; pins are sampled on pclk through the line monitor.
`timescale 1ns/1ns
`default_nettype none
module isrb_slave
	import isrb_pkg::*;
(
	// System
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Two-wire pins
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe
);
	isrb_line_if ln ();
	isrb_state_e st_reg;

	logic             en_reg;
	logic             mode_reg;
	logic             hwa_reg;
	logic             sel_reg;
	logic             req_reg;
	logic [6:0]       own_adr_reg;
	logic             done_reg;
	logic             stall_reg;
	logic             sda_low_reg;
	logic             ref_reg;
	logic             busy_reg;
	logic             dir_reg;
	logic             addr_ph_reg;
	logic             first_reg;
	logic             over_reg;
	logic             ack_ok_reg;
	logic             hold_adr_reg;
	logic             nack_reg;
	logic [3:0]       bitcnt_reg;
	logic [7:0]       shift_reg;
	logic [7:0]       tx_reg;
	logic [7:0]       pf_reg;
	logic [7:0]       byte_holding_reg;
	logic [PTR_W-1:0] base_buffer_pointer;
	logic [PTR_W-1:0] current_buffer_pointer;
	logic [PTR_W-1:0] cpu_side_base_pointer;
	logic [7:0]       mem [BUF_DEPTH];
	logic [31:0]      prdata_reg;

	isrb_line_mon u_mon (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.ln      (ln)
	);

	// ==========================================
	// APB decode
	wire setup    = psel & ~penable & ce;
	wire acc      = psel & penable & ce;
	wire wr_en    = acc & pwrite;
	wire rd_en    = acc & ~pwrite;
	wire hit      = (paddr == OFF_CTRL) | (paddr == OFF_STAT) | (paddr == OFF_DATA) | (paddr == OFF_CMD)
	              | (paddr == OFF_BP) | (paddr == OFF_BUF) | (paddr == OFF_PTR);
	wire buf_cpu  = acc & (paddr == OFF_BUF);
	wire data_wr  = wr_en & (paddr == OFF_DATA);
	wire stat_wr  = wr_en & (paddr == OFF_STAT);
	wire cmd_wr   = wr_en & (paddr == OFF_CMD) & (st_reg == S_HOLD);
	wire cmd_ack  = pwdata[CMD_ACK];

	// ==========================================
	// Engine decode
	wire refuse   = mode_reg & ref_reg;
	wire auto_adr = mode_reg & hwa_reg;
	wire adr_hit  = shift_reg[7:1] == own_adr_reg;
	wire byte_in  = (st_reg == S_RX) & ln.scl_fall & (bitcnt_reg == BITS_RX);
	wire ptr_bad  = shift_reg > PTR_MAX8;
	wire buf_rx   = byte_in & ~addr_ph_reg & mode_reg;
	wire rx_ok    = (first_reg ? ~ptr_bad : ~over_reg) & ~refuse;
	wire ptr_ld   = buf_rx & first_reg & rx_ok;
	wire buf_wr   = buf_rx & ~first_reg & rx_ok;
	wire auto_acc = byte_in & addr_ph_reg & auto_adr & adr_hit & ~refuse;
	wire hold_acc = cmd_wr & hold_adr_reg & cmd_ack & ~refuse;
	wire acc_ev   = auto_acc | hold_acc;
	wire tx_done  = (st_reg == S_TX) & ln.scl_fall & (bitcnt_reg == BITS_TX);
	wire ack_end  = (st_reg == S_TX_ACK) & ln.scl_fall;
	wire tx_stall = ack_end & ~nack_reg & ~mode_reg;
	wire cap_ev   = byte_in & ~(addr_ph_reg & auto_adr) & ~(~addr_ph_reg & mode_reg);
	wire bnd_ev   = ((st_reg == S_RX_ACK) & ln.scl_fall) | (ack_end & nack_reg);
	wire eng_ev   = req_reg & ~ref_reg & (~busy_reg | (sel_reg & bnd_ev));
	wire dis_ev   = ref_reg & ~req_reg & ln.start;
	wire [7:0] tx_src = mode_reg ? pf_reg : byte_holding_reg;
	wire [7:0] pf_src = over_reg ? RD_FILL : mem[current_buffer_pointer];

	// ==========================================
	// Read mux
	wire [31:0] ctrl_val = (32'(own_adr_reg) << CTL_ADR) | (32'(req_reg) << CTL_REQ) | (32'(sel_reg) << CTL_SEL)
	                     | (32'(hwa_reg) << CTL_HWA) | (32'(mode_reg) << CTL_MODE) | (32'(en_reg) << CTL_EN);
	wire [31:0] stat_val = (32'(busy_reg) << STA_BUSY) | (32'(dir_reg) << STA_DIR) | (32'(ref_reg) << STA_REF)
	                     | (32'(stall_reg) << STA_STALL) | (32'(done_reg) << STA_DONE);
	wire [31:0] ptr_val  = (32'(current_buffer_pointer) << PTR_CP) | 32'(base_buffer_pointer);
	wire [31:0] rd_mux   = (paddr == OFF_CTRL) ? ctrl_val
	                     : (paddr == OFF_STAT) ? stat_val
	                     : (paddr == OFF_DATA) ? 32'(byte_holding_reg)
	                     : (paddr == OFF_BP)   ? 32'(cpu_side_base_pointer)
	                     : (paddr == OFF_BUF)  ? 32'(mem[cpu_side_base_pointer])
	                     : (paddr == OFF_PTR)  ? ptr_val : 32'h0;

	// Zero wait states; a frozen block holds the access open
	assign pready  = ce;
	assign pslverr = psel & penable & ~hit;
	assign prdata  = prdata_reg;
	assign scl_o   = 1'b0;
	assign sda_o   = 1'b0;
	assign scl_oe  = stall_reg;
	assign sda_oe  = sda_low_reg;

	// ==========================================
	// Registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{en_reg, mode_reg, hwa_reg, sel_reg, req_reg} <= 5'h00;
			own_adr_reg <= OWN_ADR_RST;
			cpu_side_base_pointer <= '0;
			prdata_reg <= 32'h0;
		end
		else
		begin
			if (setup)
				prdata_reg <= rd_mux;
			if (wr_en & (paddr == OFF_CTRL))
			begin
				en_reg      <= pwdata[CTL_EN];
				mode_reg    <= pwdata[CTL_MODE];
				hwa_reg     <= pwdata[CTL_HWA];
				sel_reg     <= pwdata[CTL_SEL];
				req_reg     <= pwdata[CTL_REQ];
				own_adr_reg <= pwdata[CTL_ADR +: 7];
			end
			if (wr_en & (paddr == OFF_BP))
				cpu_side_base_pointer <= pwdata[PTR_W-1:0];
			else if (buf_cpu)
				cpu_side_base_pointer <= cpu_side_base_pointer + PTR_ONE;
		end
	end

	// Hardware set wins over a same-cycle clear
	// byte complete flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			done_reg <= 1'b0;
		else if (ce & (cap_ev | tx_stall))
			done_reg <= 1'b1;
		else if (stat_wr & pwdata[STA_DONE])
			done_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			byte_holding_reg <= 8'h00;
		else if (ce & cap_ev)
			byte_holding_reg <= shift_reg;
		else if (data_wr)
			byte_holding_reg <= pwdata[7:0];
	end

	// ==========================================
	// Refusal handshake
	// engage when free, or at a byte boundary when sel is set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ref_reg  <= 1'b0;
			busy_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (ln.start)
				busy_reg <= 1'b1;
			else if (ln.stop)
				busy_reg <= 1'b0;
			if (eng_ev)
				ref_reg <= 1'b1;
			else if (dis_ev)
				ref_reg <= 1'b0;
		end
	end

	// ==========================================
	// Buffer and pointers
	// two independent ports
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			base_buffer_pointer    <= '0;
			current_buffer_pointer <= '0;
			over_reg <= 1'b0;
			pf_reg   <= 8'h00;
		end
		else if (ce)
		begin
			if (acc_ev & mode_reg)
			begin
				over_reg <= shift_reg[0] & (base_buffer_pointer == PTR_LAST);
				current_buffer_pointer <= shift_reg[0] ? ptr_inc(base_buffer_pointer) : base_buffer_pointer;
				if (shift_reg[0])
					pf_reg <= mem[base_buffer_pointer];
			end
			else if (ptr_ld)
			begin
				base_buffer_pointer    <= shift_reg[PTR_W-1:0];
				current_buffer_pointer <= shift_reg[PTR_W-1:0];
				over_reg <= 1'b0;
			end
			else if (buf_wr)
			begin
				current_buffer_pointer <= ptr_inc(current_buffer_pointer);
				over_reg <= current_buffer_pointer == PTR_LAST;
			end
			else if (tx_done & mode_reg)
			begin
				pf_reg <= pf_src;
				current_buffer_pointer <= ptr_inc(current_buffer_pointer);
				over_reg <= over_reg | (current_buffer_pointer == PTR_LAST);
			end
		end
	end

	// Storage has no reset; the master port is written last so it wins on a shared entry
	// two write ports
	always_ff @(posedge pclk)
	begin
		if (ce & buf_cpu & pwrite)
			mem[cpu_side_base_pointer] <= pwdata[7:0];
		if (ce & buf_wr)
			mem[current_buffer_pointer] <= shift_reg;
	end

	// ==========================================
	// Bus engine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= S_IDLE;
			{stall_reg, sda_low_reg, dir_reg, addr_ph_reg, first_reg} <= 5'h00;
			{ack_ok_reg, hold_adr_reg, nack_reg} <= 3'h0;
			bitcnt_reg <= 4'h0;
			shift_reg  <= 8'h00;
			tx_reg     <= 8'h00;
		end
		else if (ce)
		begin
			if (ln.stop)
			begin
				st_reg      <= S_IDLE;
				stall_reg   <= 1'b0;
				sda_low_reg <= 1'b0;
			end
			else if (ln.start & en_reg)
			begin
				st_reg      <= S_RX;
				bitcnt_reg  <= 4'h0;
				addr_ph_reg <= 1'b1;
				first_reg   <= 1'b1;
				stall_reg   <= 1'b0;
				sda_low_reg <= 1'b0;
			end
			else
			begin
				case (st_reg)
					S_RX:
					begin
						if (ln.scl_rise)
						begin
							shift_reg  <= {shift_reg[6:0], ln.sda};
							bitcnt_reg <= bitcnt_reg + BIT_ONE;
						end
						else if (byte_in)
						begin
							if (addr_ph_reg & auto_adr)
							begin
								st_reg      <= adr_hit ? S_RX_ACK : S_IDLE;
								sda_low_reg <= adr_hit & ~refuse;
								ack_ok_reg  <= ~refuse;
								dir_reg     <= shift_reg[0];
							end
							else if (mode_reg & ~addr_ph_reg)
							begin
								st_reg      <= S_RX_ACK;
								sda_low_reg <= rx_ok;
								ack_ok_reg  <= rx_ok;
								first_reg   <= 1'b0;
							end
							else
							begin
								st_reg       <= S_HOLD;
								stall_reg    <= 1'b1;
								hold_adr_reg <= addr_ph_reg;
							end
						end
					end
					S_RX_ACK:
					begin
						if (ln.scl_fall)
						begin
							sda_low_reg <= 1'b0;
							addr_ph_reg <= 1'b0;
							bitcnt_reg  <= 4'h0;
							if (!ack_ok_reg)
								st_reg <= S_WAIT;
							else if (dir_reg)
							begin
								tx_reg      <= tx_src;
								sda_low_reg <= ~tx_src[7];
								st_reg      <= S_TX;
							end
							else
								st_reg <= S_RX;
						end
					end
					S_TX:
					begin
						if (tx_done)
						begin
							sda_low_reg <= 1'b0;
							st_reg      <= S_TX_ACK;
						end
						else if (ln.scl_fall)
						begin
							tx_reg      <= {tx_reg[6:0], 1'b0};
							sda_low_reg <= ~tx_reg[6];
							bitcnt_reg  <= bitcnt_reg + BIT_ONE;
						end
					end
					S_TX_ACK:
					begin
						if (ln.scl_rise)
							nack_reg <= ln.sda;
						else if (ack_end)
						begin
							bitcnt_reg <= 4'h0;
							if (nack_reg)
								st_reg <= S_WAIT;
							else if (mode_reg)
							begin
								tx_reg      <= pf_reg;
								sda_low_reg <= ~pf_reg[7];
								st_reg      <= S_TX;
							end
							else
							begin
								stall_reg    <= 1'b1;
								hold_adr_reg <= 1'b0;
								st_reg       <= S_HOLD;
							end
						end
					end
					S_HOLD:
					begin
						if (cmd_wr)
						begin
							stall_reg  <= 1'b0;
							bitcnt_reg <= 4'h0;
							if (hold_adr_reg)
								dir_reg <= shift_reg[0];
							if (!hold_adr_reg & dir_reg)
							begin
								tx_reg      <= byte_holding_reg;
								sda_low_reg <= ~byte_holding_reg[7];
								st_reg      <= S_TX;
							end
							else
							begin
								ack_ok_reg  <= cmd_ack & ~refuse;
								sda_low_reg <= cmd_ack & ~refuse;
								st_reg      <= S_RX_ACK;
							end
						end
					end
					S_IDLE, S_WAIT:
						st_reg <= st_reg;
					default:
						st_reg <= S_IDLE;
				endcase
			end
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_held;
		ce && stall_reg && !cmd_wr && !ln.stop;
	endsequence

	sequence s_stall_begin;
		!stall_reg ##1 stall_reg;
	endsequence

	a_stall_held: assert property (s_held |=> stall_reg)
		else $error("stall released without command or stop");
	a_stall_flags: assert property (s_stall_begin |-> done_reg)
		else $error("stall without byte complete flag");
	a_buf_nostall: assert property (stall_reg && mode_reg |-> hold_adr_reg && !hwa_reg)
		else $error("buffered mode stalled on data");
	a_ptr_refused: assert property (ce && buf_rx && first_reg && ptr_bad |=> !sda_low_reg)
		else $error("pointer above range acked");
	a_refuse_nack: assert property (ce && byte_in && addr_ph_reg && auto_adr && refuse |=> !sda_low_reg)
		else $error("address acked while refusing");
	a_engage_free: assert property (ce && req_reg && !ref_reg && !busy_reg |=> ref_reg)
		else $error("refusal not engaged on idle bus");
	a_engage_stop: assert property (ce && !ref_reg && busy_reg && !sel_reg |=> !ref_reg)
		else $error("refusal engaged before stop");
	a_leave_start: assert property (ce && dis_ev && !eng_ev |=> !ref_reg)
		else $error("refusal kept after start");
	a_stop_idle: assert property (ce && ln.stop |=> st_reg == S_IDLE && !stall_reg && !sda_low_reg)
		else $error("stop did not return to idle");
	a_cp_step: assert property (ce && buf_wr && !acc_ev |=>
		current_buffer_pointer == ptr_inc($past(current_buffer_pointer)))
		else $error("current pointer did not step");
	a_cp_reload: assert property (ce && acc_ev && mode_reg && !shift_reg[0] |=>
		current_buffer_pointer == $past(base_buffer_pointer))
		else $error("pointer not reloaded from base");
endmodule
`default_nettype wire

// ### rtl/isrb_pkg.sv
// Shared constants, state type and helpers of the two-wire slave with RAM buffer.
// Assumes a 20 MHz APB clock and an external master clocking at up to 400 kHz.
`default_nettype none
package isrb_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_CMD  = 8'h0c;
	localparam logic [7:0] OFF_BP   = 8'h10;
	localparam logic [7:0] OFF_BUF  = 8'h14;
	localparam logic [7:0] OFF_PTR  = 8'h18;

	// ==========================================
	// Field positions
	localparam int CTL_EN   = 0;
	localparam int CTL_MODE = 1;
	localparam int CTL_HWA  = 2;
	localparam int CTL_SEL  = 3;
	localparam int CTL_REQ  = 4;
	localparam int CTL_ADR  = 8;
	localparam int STA_DONE = 0;
	localparam int STA_STALL = 1;
	localparam int STA_REF  = 2;
	localparam int STA_DIR  = 3;
	localparam int STA_BUSY = 4;
	localparam int CMD_ACK  = 0;
	localparam int PTR_CP   = 8;

	// ==========================================
	// Sizes and reset values
	localparam int PTR_W = 5;
	localparam int BUF_DEPTH = 32;
	localparam logic [PTR_W-1:0] PTR_LAST = 5'h1f;
	localparam logic [PTR_W-1:0] PTR_ONE  = 5'h01;
	localparam logic [7:0] PTR_MAX8 = 8'h1f;
	localparam logic [3:0] BITS_RX  = 4'h8;
	localparam logic [3:0] BITS_TX  = 4'h7;
	localparam logic [3:0] BIT_ONE  = 4'h1;
	localparam logic [7:0] RD_FILL  = 8'hff;
	localparam logic [6:0] OWN_ADR_RST = 7'h2a;

	typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK, S_HOLD, S_WAIT} isrb_state_e;

	// Pointer step that sticks at the last buffer entry
	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		return (p == PTR_LAST) ? p : p + PTR_ONE;
	endfunction
endpackage
`default_nettype wire

// ### rtl/isrb_line_if.sv
// Bus-line events passed from the line monitor to the slave engine.
// Assumes both ends run on pclk.
`timescale 1ns/1ns
`default_nettype none
interface isrb_line_if;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	modport mon (output sda, scl_rise, scl_fall, start, stop);
	modport eng (input sda, scl_rise, scl_fall, start, stop);
endinterface
`default_nettype wire

// ### rtl/isrb_line_mon.sv
// Line monitor: synchronises the clock and data pins and finds edges, Start and Stop.
// Assumes pins from another domain; pclk is at least 20x the bus clock.
`timescale 1ns/1ns
`default_nettype none
module isrb_line_mon
	import isrb_pkg::*;
(
	// System
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// Pins
	input  wire logic scl_i,
	input  wire logic sda_i,
	// Events
	isrb_line_if.mon  ln
);
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic       scl_prev_reg;
	logic       sda_prev_reg;

	// ==========================================
	// Synchronisers
	// two-stage sampling
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else if (ce)
		begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	// ==========================================
	// Events
	wire scl_now = scl_sync_reg[1];
	wire sda_now = sda_sync_reg[1];
	wire scl_high = scl_now & scl_prev_reg;

	assign ln.sda      = sda_now;
	assign ln.scl_rise = scl_now & ~scl_prev_reg;
	assign ln.scl_fall = ~scl_now & scl_prev_reg;
	// Data moving while the clock stays high frames a transfer
	assign ln.start    = scl_high & sda_prev_reg & ~sda_now;
	assign ln.stop     = scl_high & ~sda_prev_reg & sda_now;
endmodule
`default_nettype wire

// ### sim/isrb_master_model.sv
// Two-wire bus master model; drives open-drain enables only.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/1ns
`default_nettype none
module isrb_master_model
(
	// Resolved lines
	input  wire logic scl,
	input  wire logic sda,
	// Pull-down enables
	output var logic  scl_oe,
	output var logic  sda_oe
);
	// Set when a stalled clock is never released; the bench counts it as a mismatch
	logic hung = 1'b0;

	initial
	begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end

	// ==========================================
	// Bit timing
	// 2.5 MHz clock (400 ns per bit)
	task automatic pulse(output logic b);
		int n;
		#150 scl_oe = 1'b0;
		n = 0;
		while (scl !== 1'b1 && n < 2000)
		begin
			#10 n++;
		end
		if (scl !== 1'b1)
			hung = 1'b1;
		#100 b = sda;
		#100 scl_oe = 1'b1;
		#50;
	endtask

	task automatic start_cond();
		// Extra 10 ns keeps line edges off the sampling clock's edges
		#110 sda_oe = 1'b1;
		#100 scl_oe = 1'b1;
		#50;
	endtask

	task automatic stop_cond();
		sda_oe = 1'b1;
		#150 scl_oe = 1'b0;
		#100 sda_oe = 1'b0;
		#200;
	endtask

	// ==========================================
	// Bytes, MSB first
	// address or data byte, then the acknowledge bit
	task automatic send_byte(input logic [7:0] v, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
		begin
			sda_oe = ~v[i];
			pulse(b);
		end
		sda_oe = 1'b0;
		pulse(b);
		ack = ~b;
	endtask

	task automatic get_byte(input logic ack, output logic [7:0] v);
		logic b;
		sda_oe = 1'b0;
		for (int i = 7; i >= 0; i--)
			pulse(v[i]);
		sda_oe = ack;
		pulse(b);
		sda_oe = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### sim/isrb_slave_tb_top.sv
// Bench for the two-wire RAM-buffer slave: APB driver, reference buffer, checks.
// Assumes the master model and pull-ups on both lines.
`timescale 1ns/1ns
`default_nettype none
module isrb_slave_tb_top
	import isrb_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scl_o;
	logic        scl_oe;
	logic        sda_o;
	logic        sda_oe;
	logic        m_scl_oe;
	logic        m_sda_oe;
	logic        last_err;
	logic        ack;
	logic [31:0] q;
	logic        ce = 1'b1;
	logic [7:0]  v0;
	logic [7:0]  v1;
	logic [7:0]  got;
	logic [31:0] seed = 32'h4983;
	logic [7:0]  mem [32];
	int          miscompares = 0;
	int          total_checks = 0;
	int          bp;
	int          cp;
	wire         scl = ~(m_scl_oe | (scl_oe & ~scl_o));
	wire         sda = ~(m_sda_oe | (sda_oe & ~sda_o));

	always #25 pclk = ~pclk;

	isrb_slave isrb_slave_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe));
	isrb_master_model isrb_master_model_inst (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic tally_and_finish();
		if (isrb_master_model_inst.hung)
			miscompares++;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
		begin
			miscompares++;
			tally_and_finish();
		end
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("reg", e, q);
	endtask

	task automatic addr(input logic r, input logic e);
		isrb_master_model_inst.start_cond();
		isrb_master_model_inst.send_byte({OWN_ADR_RST, r}, ack);
		chk("adr_ack", 32'(e), 32'(ack));
	endtask

	task automatic poll(input int b);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, OFF_STAT, 32'h0);
			n++;
		end
		while (q[b] !== 1'b1 && n < 100);
	endtask

	// Firmware side of one compatible-mode stall: check, load the byte, then release
	task automatic service(input logic [7:0] e, input logic [7:0] tx, input logic a);
		poll(STA_STALL);
		chk("stall", 32'h1, 32'(q[STA_STALL]));
		rd(OFF_DATA, 32'(e));
		apb(1'b1, OFF_DATA, 32'(tx));
		apb(1'b1, OFF_CMD, 32'(a));
	endtask

	// Reference pointer model: saturates at the last entry, then refuses
	task automatic wr_xfer(input logic [7:0] ptr, input int n);
		logic [7:0] b;
		int full;
		addr(1'b0, 1'b1);
		isrb_master_model_inst.send_byte(ptr, ack);
		chk("ptr_ack", 32'(ptr <= 8'h1f), 32'(ack));
		if (ptr <= 8'h1f)
		begin
			bp = ptr;
			cp = ptr;
			full = 0;
			for (int i = 0; i < n; i++)
			begin
				b = 8'(rnd());
				isrb_master_model_inst.send_byte(b, ack);
				chk("wr_ack", 32'(full == 0), 32'(ack));
				if (full == 0)
					mem[cp] = b;
				if (cp == 31)
					full = 1;
				else if (full == 0)
					cp++;
			end
		end
		isrb_master_model_inst.stop_cond();
		if (ptr <= 8'h1f)
			rd(OFF_PTR, 32'((cp << 8) | bp));
	endtask

	task automatic rd_xfer(input int n);
		logic [7:0] b;
		addr(1'b1, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			isrb_master_model_inst.get_byte(i != n - 1, b);
			chk("rd_data", 32'((bp + i > 31) ? RD_FILL : mem[bp + i]), 32'(b));
		end
		isrb_master_model_inst.stop_cond();
		rd(OFF_PTR, 32'((((bp + n + 1 > 31) ? 31 : bp + n + 1) << 8) | bp));
	endtask

	initial
	begin
		#4000000;
		miscompares++;
		$display("BAD watchdog exp done got hang");
		tally_and_finish();
	end

	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd(OFF_CTRL, 32'h2a00);
		apb(1'b1, 8'h40, 32'h0);
		chk("slverr", 32'h1, 32'(last_err));
		// A frozen block must hold an open access until the enable returns
		ce <= 1'b0;
		fork
			apb(1'b1, OFF_BP, 32'h3);
			begin
				repeat (5) @(posedge pclk);
				ce <= 1'b1;
			end
		join
		rd(OFF_BP, 32'h3);
		// Compatible mode: firmware services every byte while the clock is stalled
		apb(1'b1, OFF_CTRL, 32'h2a01);
		v0 = 8'(rnd());
		v1 = 8'(rnd());
		fork
			begin
				addr(1'b0, 1'b1);
				isrb_master_model_inst.send_byte(v0, ack);
				chk("cmp_wr_ack", 32'h1, 32'(ack));
				isrb_master_model_inst.stop_cond();
				addr(1'b1, 1'b1);
				isrb_master_model_inst.get_byte(1'b1, got);
				chk("cmp_rd0", 32'(v0), 32'(got));
				isrb_master_model_inst.get_byte(1'b0, got);
				chk("cmp_rd1", 32'(v1), 32'(got));
				isrb_master_model_inst.stop_cond();
			end
			begin
				service({OWN_ADR_RST, 1'b0}, 8'h00, 1'b1);
				service(v0, 8'h00, 1'b1);
				service({OWN_ADR_RST, 1'b1}, v0, 1'b1);
				service(v0, v1, 1'b0);
			end
		join
		apb(1'b1, OFF_CTRL, 32'h2a07);
		isrb_master_model_inst.start_cond();
		isrb_master_model_inst.send_byte(8'h56, ack);
		isrb_master_model_inst.stop_cond();
		chk("nack_other", 32'h0, 32'(ack));
		wr_xfer(8'(rnd() % 28), 4);
		apb(1'b1, OFF_BP, 32'(bp));
		for (int i = 0; i < 4; i++)
			rd(OFF_BUF, 32'(mem[bp + i]));
		wr_xfer(8'h20, 0);
		wr_xfer(8'h1e, 3);
		apb(1'b1, OFF_BP, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			mem[i] = 8'(rnd());
			apb(1'b1, OFF_BUF, 32'(mem[i]));
		end
		wr_xfer(8'h00, 0);
		repeat (2) rd_xfer(3);
		wr_xfer(8'h1f, 0);
		rd_xfer(2);
		addr(1'b0, 1'b1);
		apb(1'b1, OFF_CTRL, 32'h2a17);
		apb(1'b0, OFF_STAT, 32'h0);
		chk("ref_busy", 32'h0, 32'(q[STA_REF]));
		isrb_master_model_inst.stop_cond();
		poll(STA_REF);
		chk("ref_flag", 32'h1, 32'(q[STA_REF]));
		addr(1'b0, 1'b0);
		isrb_master_model_inst.stop_cond();
		apb(1'b1, OFF_CTRL, 32'h2a07);
		addr(1'b0, 1'b1);
		isrb_master_model_inst.stop_cond();
		// Byte-boundary timing: refusal takes hold inside a busy transfer
		apb(1'b1, OFF_CTRL, 32'h2a0f);
		addr(1'b0, 1'b1);
		apb(1'b1, OFF_CTRL, 32'h2a1f);
		apb(1'b0, OFF_STAT, 32'h0);
		chk("ref_wait", 32'h0, 32'(q[STA_REF]));
		isrb_master_model_inst.send_byte(8'h01, ack);
		chk("ref_bnd_ack", 32'h1, 32'(ack));
		poll(STA_REF);
		chk("ref_bnd", 32'h3, 32'({q[STA_BUSY], q[STA_REF]}));
		isrb_master_model_inst.stop_cond();
		tally_and_finish();
	end
endmodule
`default_nettype wire
